// ==== board_cache_control_regs.sv ====
/*
  board cache control register bank: configuration, error address,
  error and clock status, extra configuration, plus the timing outputs
  that the configuration drives.
  assumes a single-cycle register port from the load/store unit, with
  rd_en and wr_en as one-cycle pulses on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module board_cache_control_regs (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        timeout_reset,
  input  wire logic [3:0]  irq_pins,
  input  wire logic [39:0] reg_addr,
  input  wire logic        rd_en,
  input  wire logic        wr_en,
  input  wire logic [63:0] wr_data,
  output logic      [63:0] rd_data,
  output logic             rd_hit,
  input  wire logic        txn_start,
  input  wire logic        txn_fill,
  input  wire logic        txn_read,
  input  wire logic        txn_write,
  input  wire logic [39:0] txn_pa,
  input  wire logic [3:0]  lw_parity_bad,
  input  wire logic        tag_parity_bad,
  input  wire logic        tag_dirty_in,
  input  wire logic        cache_hit_raw,
  input  wire logic [7:0]  events_a,
  input  wire logic [7:0]  events_b,
  input  wire logic        lw_writing,
  input  wire logic [3:0]  lw_bit0_in,
  output logic      [3:0]  lw_bit0_out,
  output logic             strobe_clock,
  output logic             capture_now,
  output logic             write_allowed,
  output logic             cache_hit,
  output logic             error_event,
  output logic             count_a,
  output logic             count_b,
  output logic      [2:0]  tag_write_bits,
  output logic             probe_during_fill,
  output logic             triple_miss_allow,
  output logic             registered_sram_select,
  output logic             early_tag_oe_release,
  output logic             debug_group_select,
  output logic      [1:0]  capacity_code
);
  logic        rst_meta;
  logic        rst_n;
  logic [31:0] cache_config;
  logic [15:0] cache_config_extra;
  logic [3:0]  irq_meta;
  logic [3:0]  irq_sync;
  logic [3:0]  system_period;
  logic        strap_done;
  logic [4:0]  lat_cnt;
  logic [3:0]  gap_cnt;
  logic        last_was_read;
  logic        strobe_raw;
  reg_access_if acc ();

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // field views
  wire        cache_on    = cache_config[cache_regs_pkg::ON_BIT];
  wire [3:0]  period      = cache_config[cache_regs_pkg::PERIOD_LSB +: 4];
  wire [3:0]  latency_off = cache_config[cache_regs_pkg::LATENCY_LSB +: 4];
  wire [1:0]  strobe_lag  = cache_config[cache_regs_pkg::LAG_LSB +: 2];
  wire [2:0]  turn_off    = cache_config[cache_regs_pkg::TURN_LSB +: 3];
  wire [2:0]  fill_off    = cache_config[cache_regs_pkg::FILL_LSB +: 3];
  wire        always_hit  = cache_config[cache_regs_pkg::HIT_BIT];
  wire        inject      = cache_config[cache_regs_pkg::INJ_BIT];
  wire [2:0]  sel_a = cache_config_extra[cache_regs_pkg::CNT_A_LSB +: 3];
  wire [2:0]  sel_b = cache_config_extra[cache_regs_pkg::CNT_B_LSB +: 3];

  wire in_window  = (reg_addr & cache_regs_pkg::WINDOW_MASK) == cache_regs_pkg::WINDOW_BASE;
  wire sel_config = in_window && reg_addr == cache_regs_pkg::CONFIG_ADDR;
  wire sel_addr   = in_window && reg_addr == cache_regs_pkg::ERR_ADDR_ADDR;
  wire sel_status = in_window && reg_addr == cache_regs_pkg::STATUS_ADDR;
  wire sel_extra  = in_window && reg_addr == cache_regs_pkg::CONFIG_EXTRA_ADDR;
  wire any_sel    = sel_config | sel_addr | sel_status | sel_extra;

  // read mux with reserved bits zero
  wire [63:0] next_rd_data =
      sel_config ? {32'h0, cache_config} :
      sel_addr   ? {24'h0, acc.addr_value} :
      sel_status ? {44'h0, acc.status_value} :
      sel_extra  ? {48'h0, cache_config_extra} : 64'h0;

  assign acc.status_read = rd_en & sel_status;

  // read data register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 64'h0;
      rd_hit  <= 1'b0;
    end else begin
      rd_data <= rd_en ? next_rd_data : 64'h0;
      rd_hit  <= rd_en & any_sel;
    end
  end

  // config keeps value across timeout reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      cache_config <= cache_regs_pkg::CONFIG_RESET;
    else if (wr_en && sel_config)
      cache_config <= wr_data[31:0] & cache_regs_pkg::CONFIG_WMASK;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      cache_config_extra <= cache_regs_pkg::EXTRA_RESET;
    else if (timeout_reset)
      cache_config_extra <= cache_regs_pkg::EXTRA_RESET;
    else if (wr_en && sel_extra)
      cache_config_extra <= wr_data[15:0] & cache_regs_pkg::EXTRA_WMASK;
  end

  // interrupt pins synchronised, captured after reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_meta      <= 4'h0;
      irq_sync      <= 4'h0;
      system_period <= 4'h0;
      strap_done    <= 1'b0;
    end else begin
      irq_meta   <= irq_pins;
      irq_sync   <= irq_meta;
      strap_done <= 1'b1;
      if (strap_done && !timeout_reset && system_period == 4'h0)
        system_period <= irq_sync;
    end
  end

  wire par_on = txn_pa[39] ? cache_config[cache_regs_pkg::IO_PAR_BIT]
                           : cache_config[cache_regs_pkg::MEM_PAR_BIT];
  wire par_fail = txn_read && par_on && (lw_parity_bad != 4'h0 || tag_parity_bad);

  error_logger u_logger (
    .clk           (ref_clk),
    .rst_n         (rst_n),
    .error_valid   (par_fail),
    .error_pa      (txn_pa),
    .error_lw      (lw_parity_bad),
    .error_tag     (tag_parity_bad),
    .error_dirty   (tag_dirty_in),
    .error_fill    (txn_fill),
    .system_period (system_period),
    .acc           (acc)
  );

  wire [4:0] strobe_delay = txn_fill
      ? cache_regs_pkg::FILL_BASE + {2'h0, fill_off} + {3'h0, strobe_lag}
      : {3'h0, strobe_lag};

  strobe_timer u_strobe (
    .clk    (ref_clk),
    .rst_n  (rst_n),
    .enable (cache_on),
    .period (period),
    .start  (txn_start),
    .delay  (strobe_delay),
    .strobe (strobe_raw)
  );

  // capture countdown of five plus offset
  wire [4:0] lat_load = cache_regs_pkg::LATENCY_BASE + {1'b0, latency_off} - 5'h01;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      lat_cnt <= 5'h00;
    else if (txn_start && txn_read)
      lat_cnt <= lat_load;
    else if (lat_cnt != 5'h00)
      lat_cnt <= lat_cnt - 5'h01;
  end
  wire next_capture = lat_cnt == 5'h01;

  wire [3:0] gap_load = cache_regs_pkg::GAP_BASE + {1'b0, turn_off};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt       <= 4'h0;
      last_was_read <= 1'b0;
    end else begin
      if (txn_start)
        last_was_read <= txn_read;
      if (txn_start && txn_write && last_was_read)
        gap_cnt <= gap_load - 4'h1;
      else if (gap_cnt != 4'h0)
        gap_cnt <= gap_cnt - 4'h1;
    end
  end
  wire next_write_ok = gap_cnt == 4'h0 && !(txn_start && txn_write && last_was_read);

  // forced hit for memory space; cache off sends to memory
  wire next_hit = cache_on && (cache_hit_raw || (always_hit && !txn_pa[39]));
  // inverted bit zero per written longword
  wire [3:0] next_lw_bit0 = lw_bit0_in ^ {4{inject & lw_writing}};
  // event selection; code 4 of counter a counts nothing
  wire next_count_a = sel_a == 3'h4 ? 1'b0 : events_a[sel_a];
  wire next_count_b = events_b[sel_b];

  // registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_clock  <= 1'b0;
      capture_now   <= 1'b0;
      write_allowed <= 1'b1;
      cache_hit     <= 1'b0;
      error_event   <= 1'b0;
      count_a       <= 1'b0;
      count_b       <= 1'b0;
      lw_bit0_out   <= 4'h0;
    end else begin
      strobe_clock  <= strobe_raw;
      capture_now   <= next_capture;
      write_allowed <= next_write_ok;
      cache_hit     <= next_hit;
      error_event   <= par_fail;
      count_a       <= next_count_a;
      count_b       <= next_count_b;
      lw_bit0_out   <= next_lw_bit0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tag_write_bits         <= 3'h0;
      probe_during_fill      <= 1'b0;
      triple_miss_allow      <= 1'b0;
      registered_sram_select <= 1'b1;
      early_tag_oe_release   <= 1'b0;
      debug_group_select     <= 1'b0;
      capacity_code          <= 2'h3;
    end else begin
      tag_write_bits         <= always_hit ? cache_config[cache_regs_pkg::TAG_LSB +: 3] : 3'h0;
      probe_during_fill      <= cache_config[cache_regs_pkg::PDF_BIT];
      triple_miss_allow      <= cache_config_extra[cache_regs_pkg::TRIPLE_BIT];
      registered_sram_select <= cache_config_extra[cache_regs_pkg::REGSRAM_BIT];
      early_tag_oe_release   <= cache_config[cache_regs_pkg::PDF_BIT] &
                                cache_config_extra[cache_regs_pkg::EARLY_BIT];
      debug_group_select     <= cache_config_extra[cache_regs_pkg::DBG_BIT];
      capacity_code          <= cache_config[cache_regs_pkg::CAPACITY_LSB +: 2];
    end
  end

  cfg_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && sel_config |=> cache_config == ($past(wr_data[31:0]) & cache_regs_pkg::CONFIG_WMASK))
    else $error("config write not stored");
  window_miss_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_en && !in_window |=> !rd_hit && rd_data == 64'h0)
    else $error("access outside window answered");
  timeout_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timeout_reset && !(wr_en && sel_config) |=> $stable(cache_config))
    else $error("config changed on timeout reset");
  latency_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    txn_start && txn_read && latency_off == 4'h2 |-> ##7 capture_now)
    else $error("capture not at seven cycles");
  force_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cache_on && always_hit && !txn_pa[39] |=> cache_hit)
    else $error("forced hit missing");
  inject_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    inject && lw_writing |=> lw_bit0_out == ~$past(lw_bit0_in))
    else $error("bit zero not inverted");
  gap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    txn_start && txn_write && last_was_read && turn_off >= 3'h2 |=> !write_allowed [*3])
    else $error("read to write gap too short");
  cnt_a_undef_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sel_a == 3'h4 |=> !count_a)
    else $error("undefined event counted");
  err_log_c: cover property (@(posedge ref_clk) disable iff (!rst_n) par_fail ##[1:8] acc.status_read);
  fill_txn_c: cover property (@(posedge ref_clk) disable iff (!rst_n) txn_start && txn_fill);
  cfg_wr_c: cover property (@(posedge ref_clk) disable iff (!rst_n) wr_en && sel_config);
endmodule
`default_nettype wire

// ==== board_cache_control_regs_tb.sv ====
/*
  self-checking bench for the cache control register bank: reset values,
  reserved bits, refused accesses, error lock and clear, latency, timeout reset.
  assumes the design files and the package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module board_cache_control_regs_tb;
  localparam logic [3:0]  SYS_STRAP = 4'h7;
  localparam logic [63:0] STAT_IDLE = {52'h0, cache_regs_pkg::REVISION_CODE, SYS_STRAP, 4'h0};
  localparam logic [39:0] PA1       = 40'h00_1234_5678;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        timeout_reset = 1'b0;
  logic        rd_en = 1'b0, wr_en = 1'b0, txn_start = 1'b0, txn_fill = 1'b0, txn_read = 1'b0;
  logic        txn_write = 1'b0, tag_bad = 1'b0, lw_writing = 1'b0;
  logic [39:0] reg_addr = '0, txn_pa = '0;
  logic [63:0] wr_data = '0;
  logic [3:0]  lw_bad = '0, lw_bit0_in = '0;
  logic [63:0] rd_data;
  logic        rd_hit, capture_now, error_event;
  logic [3:0]  lw_bit0_out;
  logic [1:0]  capacity_code;
  logic        strobe_clock, write_allowed, cache_hit, count_a, count_b, probe_during_fill;
  logic        triple_miss_allow, registered_sram_select, early_tag_oe_release, debug_group_select;
  logic [2:0]  tag_write_bits;
  logic [7:0]  events = 8'h90;
  logic        hit_raw = 1'b1, strobe_seen = 1'b0;
  int          err_total = 0;
  int          n_tests = 0;

  // free-running cpu clock
  always #5 ref_clk = ~ref_clk;

  board_cache_control_regs uut (.ref_clk(ref_clk), .reset_n(reset_n), .timeout_reset(timeout_reset),
    .irq_pins(SYS_STRAP), .reg_addr(reg_addr), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data),
    .rd_data(rd_data), .rd_hit(rd_hit), .txn_start(txn_start), .txn_fill(txn_fill),
    .txn_read(txn_read), .txn_write(txn_write), .txn_pa(txn_pa), .lw_parity_bad(lw_bad),
    .tag_parity_bad(tag_bad), .tag_dirty_in(tag_bad), .cache_hit_raw(hit_raw), .events_a(events),
    .events_b(events), .lw_writing(lw_writing), .lw_bit0_in(lw_bit0_in), .lw_bit0_out(lw_bit0_out),
    .strobe_clock(strobe_clock), .capture_now(capture_now), .write_allowed(write_allowed),
    .cache_hit(cache_hit), .error_event(error_event), .count_a(count_a), .count_b(count_b),
    .tag_write_bits(tag_write_bits), .probe_during_fill(probe_during_fill),
    .triple_miss_allow(triple_miss_allow), .registered_sram_select(registered_sram_select),
    .early_tag_oe_release(early_tag_oe_release), .debug_group_select(debug_group_select),
    .capacity_code(capacity_code));

  // one compare for every 64-bit result
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // register read, answer registered on the taking edge and checked just after it
  task automatic rd(input logic [39:0] a, input logic [63:0] exp, input logic hit);
    @(posedge ref_clk);
    reg_addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk("rd_data", exp, rd_data);
    chk("rd_hit", {63'h0, hit}, {63'h0, rd_hit});
  endtask

  task automatic wr(input logic [39:0] a, input logic [63:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // one read fill or write transaction with given parity faults
  task automatic txn(input logic [39:0] pa, input logic [3:0] lw, input logic tag, input logic w);
    @(posedge ref_clk);
    txn_start <= 1'b1;
    txn_read <= ~w;
    txn_write <= w;
    txn_fill <= ~w;
    txn_pa <= pa;
    lw_bad <= lw;
    tag_bad <= tag;
    @(posedge ref_clk);
    txn_start <= 1'b0;
    txn_read <= 1'b0;
    txn_write <= 1'b0;
    txn_fill <= 1'b0;
    lw_bad <= 4'h0;
    tag_bad <= 1'b0;
    #1;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog far beyond the roughly 115 cycles of the run
  initial begin
    #50us;
    err_total++;
    results();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    #1;
    chk("capacity_code", 64'h3, {62'h0, capacity_code});
    chk("strobe_off", 64'h0, {63'h0, strobe_clock});
    chk("cache_off_hit", 64'h0, {63'h0, cache_hit});
    rd(cache_regs_pkg::CONFIG_ADDR, 64'h0012_7030, 1'b1);
    rd(cache_regs_pkg::CONFIG_EXTRA_ADDR, 64'h10, 1'b1);
    rd(cache_regs_pkg::STATUS_ADDR, STAT_IDLE, 1'b1);
    rd(cache_regs_pkg::CONFIG_ADDR + 40'h8, 64'h0, 1'b0);
    rd(40'h00_0000_0008, 64'h0, 1'b0);
    wr(cache_regs_pkg::STATUS_ADDR, '1);
    rd(cache_regs_pkg::STATUS_ADDR, STAT_IDLE, 1'b1);
    // memory parity on, latency offset 2
    wr(cache_regs_pkg::CONFIG_ADDR, 64'h0113_3230);
    rd(cache_regs_pkg::CONFIG_ADDR, 64'h0113_3230, 1'b1);
    txn(PA1, 4'h5, 1'b1, 1'b0);
    chk("error_event", 64'h1, {63'h0, error_event});
    repeat (5) @(posedge ref_clk);
    #1;
    chk("capture_early", 64'h0, {63'h0, capture_now});
    @(posedge ref_clk);
    #1;
    chk("capture_now", 64'h1, {63'h0, capture_now});
    txn(40'h00_0ABC_DEF0, 4'h2, 1'b0, 1'b0);
    rd(cache_regs_pkg::ERR_ADDR_ADDR, {24'h0, PA1 & 40'h9F_FFFF_FFF0}, 1'b1);
    rd(cache_regs_pkg::STATUS_ADDR, STAT_IDLE | 64'hF_5000, 1'b1);
    rd(cache_regs_pkg::STATUS_ADDR, STAT_IDLE, 1'b1);
    wr(cache_regs_pkg::CONFIG_ADDR, '1);
    hit_raw <= 1'b0;
    rd(cache_regs_pkg::CONFIG_ADDR, 64'hF7FF_FFF0, 1'b1);
    chk("cache_hit", 64'h1, {63'h0, cache_hit});
    chk("tag_write_bits", 64'h7, {61'h0, tag_write_bits});
    chk("probe_during_fill", 64'h1, {63'h0, probe_during_fill});
    // strobe must run once the cache is on
    repeat (16) begin
      @(posedge ref_clk);
      #1;
      strobe_seen = strobe_seen | strobe_clock;
    end
    chk("strobe_seen", 64'h1, {63'h0, strobe_seen});
    @(posedge ref_clk);
    lw_writing <= 1'b1;
    lw_bit0_in <= 4'h5;
    @(posedge ref_clk);
    lw_writing <= 1'b0;
    #1;
    chk("lw_bit0_out", 64'hA, {60'h0, lw_bit0_out});
    wr(cache_regs_pkg::CONFIG_EXTRA_ADDR, '1);
    rd(cache_regs_pkg::CONFIG_EXTRA_ADDR, 64'hFFF0, 1'b1);
    chk("count_a", 64'h1, {63'h0, count_a});
    chk("triple_miss_allow", 64'h1, {63'h0, triple_miss_allow});
    chk("early_tag_oe_release", 64'h1, {63'h0, early_tag_oe_release});
    chk("debug_group_select", 64'h1, {63'h0, debug_group_select});
    @(posedge ref_clk);
    timeout_reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    timeout_reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(cache_regs_pkg::CONFIG_ADDR, 64'hF7FF_FFF0, 1'b1);
    rd(cache_regs_pkg::CONFIG_EXTRA_ADDR, 64'h10, 1'b1);
    // code 4 of counter a counts nothing, counter b does
    wr(cache_regs_pkg::CONFIG_EXTRA_ADDR, 64'h2400);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("count_a_undef", 64'h0, {63'h0, count_a});
    chk("count_b", 64'h1, {63'h0, count_b});
    chk("registered_sram_select", 64'h0, {63'h0, registered_sram_select});
    // read then write start: write held for 1 + 7 cycles
    txn(PA1, 4'h0, 1'b0, 1'b0);
    txn(PA1, 4'h0, 1'b0, 1'b1);
    repeat (7) @(posedge ref_clk);
    #1;
    chk("write_held", 64'h0, {63'h0, write_allowed});
    @(posedge ref_clk);
    #1;
    chk("write_allowed", 64'h1, {63'h0, write_allowed});
    results();
  end
endmodule
`default_nettype wire

// ==== cache_regs_pkg.sv ====
/*
  register map, field positions, reset values and capacity codes of the
  external interface unit's four cache control registers.
  assumes a 40-bit physical address and a 64-bit register data path.
*/
package cache_regs_pkg;
  localparam logic [39:0] WINDOW_BASE       = 40'hFF_FFF0_0000;
  localparam logic [39:0] WINDOW_MASK       = 40'hFF_FFF0_0000;
  localparam logic [39:0] CONFIG_ADDR       = 40'hFF_FFF0_0008;
  localparam logic [39:0] ERR_ADDR_ADDR     = 40'hFF_FFF0_0088;
  localparam logic [39:0] STATUS_ADDR       = 40'hFF_FFF0_0108;
  localparam logic [39:0] CONFIG_EXTRA_ADDR = 40'hFF_FFF0_0188;
  // cache_config: bits 31:4 writable, 27 reserved
  localparam logic [31:0] CONFIG_WMASK = 32'hF7FF_FFF0;
  // fill offset 1, turnaround 2, lag 1, capacity largest, period 3
  localparam logic [31:0] CONFIG_RESET = 32'h0012_7030;
  localparam int PERIOD_LSB = 4;
  localparam int LATENCY_LSB = 8;
  localparam int CAPACITY_LSB = 12;
  localparam int LAG_LSB = 14;
  localparam int TURN_LSB = 16;
  localparam int PDF_BIT = 19;
  localparam int FILL_LSB = 20;
  localparam int IO_PAR_BIT = 23;
  localparam int MEM_PAR_BIT = 24;
  localparam int HIT_BIT = 25;
  localparam int INJ_BIT = 26;
  localparam int TAG_LSB = 28;
  localparam int ON_BIT = 31;
  // cache_config_extra: bits 15:4 writable
  localparam logic [15:0] EXTRA_WMASK = 16'hFFF0;
  localparam logic [15:0] EXTRA_RESET = 16'h0010;
  localparam int REGSRAM_BIT = 4;
  localparam int DBG_BIT = 5;
  localparam int TRIPLE_BIT = 6;
  localparam int EARLY_BIT = 7;
  localparam int CNT_A_LSB = 8;
  localparam int CNT_B_LSB = 11;
  // status field positions
  localparam int SYS_LSB = 4;
  localparam int REV_LSB = 8;
  localparam int LW_LSB = 12;
  localparam int TAGERR_BIT = 16;
  localparam int DIRTY_BIT = 17;
  localparam int MEMFILL_BIT = 18;
  localparam int MULTI_BIT = 19;
  // latency base and gap base in cpu cycles
  localparam logic [4:0] LATENCY_BASE = 5'h05;
  localparam logic [3:0] GAP_BASE = 4'h1;
  localparam logic [4:0] FILL_BASE = 5'h01;
  localparam logic [3:0] REVISION_CODE = 4'hA; // value arbitrary
  typedef enum logic [1:0] {
    CAP_512K = 2'h0,
    CAP_1M   = 2'h1,
    CAP_2M   = 2'h2,
    CAP_4M   = 2'h3
  } capacity_e;
endpackage

// ==== error_logger.sv ====
/*
  error capture with lock: first error latches address and cause, later
  ones set multi-error, a status read clears and unlocks.
  assumes error_valid is a one-cycle pulse on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module error_logger (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       error_valid,
  input  wire logic [39:0] error_pa,
  input  wire logic [3:0]  error_lw,
  input  wire logic       error_tag,
  input  wire logic       error_dirty,
  input  wire logic       error_fill,
  input  wire logic [3:0]  system_period,
  reg_access_if.logger    acc
);
  logic        locked;
  logic [3:0]  lw;
  logic        tag_err;
  logic        dirty;
  logic        memfill;
  logic        multi;
  logic [39:0] addr;
  // first capture only when unlocked, or when a clear and error coincide
  wire take = error_valid & (~locked | acc.status_read);
  // multi bit: set only if already locked; a clearing read in the same cycle wins over set
  wire next_multi = error_valid & locked & ~acc.status_read;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      locked <= 1'b0;
      multi  <= 1'b0;
    end else begin
      locked <= take | (locked & ~acc.status_read);
      multi  <= next_multi | (multi & ~acc.status_read);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lw      <= 4'h0;
      tag_err <= 1'b0;
      dirty   <= 1'b0;
      memfill <= 1'b0;
      addr    <= 40'h00_0000_0000;
    end else if (take) begin
      lw      <= error_lw;
      tag_err <= error_tag;
      dirty   <= error_dirty;
      memfill <= error_fill;
      addr    <= error_pa;
    end else if (acc.status_read) begin
      lw      <= 4'h0;
      tag_err <= 1'b0;
      dirty   <= 1'b0;
      memfill <= 1'b0;
    end
  end

  // address with reserved bits forced zero
  assign acc.addr_value = {addr[39], 2'h0, addr[36:4], 4'h0};
  assign acc.status_value = {multi, memfill, dirty, tag_err, lw,
                             cache_regs_pkg::REVISION_CODE, system_period, 4'h0};

  lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    locked && !acc.status_read && error_valid |=> $stable(addr) && multi)
    else $error("locked address changed");
  clear_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    acc.status_read && !error_valid |=> !locked && !multi && lw == 4'h0)
    else $error("status read did not clear");
  first_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    error_valid && !locked |=> locked && lw == $past(error_lw) && addr == $past(error_pa))
    else $error("first error not captured");
  multi_err_c: cover property (@(posedge clk) disable iff (!rst_n) locked ##1 multi);
endmodule
`default_nettype wire

// ==== reg_access_if.sv ====
/*
  register access carrier between the decoder and the error logger.
  assumes both ends run on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
  logic        status_read;
  logic [19:0] status_value;
  logic [39:0] addr_value;
  modport logger (input status_read, output status_value, output addr_value);
  modport decoder (output status_read, input status_value, input addr_value);
endinterface
`default_nettype wire

// ==== strobe_timer.sv ====
/*
  strobe clock generator: divides the cpu clock by the programmed period
  once the cache is on; each transaction start delays the first edge.
  assumes start is a one-cycle pulse from the transaction sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
module strobe_timer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic [3:0] period,
  input  wire logic       start,
  input  wire logic [4:0] delay,
  output logic            strobe
);
  logic [3:0] phase;
  logic [4:0] wait_cnt;
  wire        waiting = wait_cnt != 5'h00;
  wire        wrap    = phase >= period - 4'h1;
  wire [3:0]  half    = period >> 1;

  // delay countdown after a transaction start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      wait_cnt <= 5'h00;
    else if (start)
      wait_cnt <= delay;
    else if (waiting)
      wait_cnt <= wait_cnt - 5'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase  <= 4'h0;
      strobe <= 1'b0;
    end else if (!enable || waiting || start) begin
      phase  <= 4'h0;
      strobe <= 1'b0;
    end else begin
      phase  <= wrap ? 4'h0 : phase + 4'h1;
      strobe <= (wrap ? 4'h0 : phase + 4'h1) < half;
    end
  end

  strobe_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> !strobe)
    else $error("strobe ran while cache off");
  strobe_lag_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && delay == 5'h02 |=> !strobe ##1 !strobe)
    else $error("strobe came before its lag");
  strobe_run_c: cover property (@(posedge clk) disable iff (!rst_n) enable ##1 strobe);
endmodule
`default_nettype wire
